// File: rsx_pkg.sv
`default_nettype none
package rsx_pkg;
  // datapath and bus widths
  localparam int DW = 8;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int FILE_DEPTH = 8;
  localparam int FILE_IDX_W = 3;
  localparam int CMD_W = 14;
  // register byte offsets
  localparam logic [AXI_AW-1:0] ADDR_ACC = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_CMD = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_WDOG = 8'h0c;
  localparam logic [AXI_AW-1:0] ADDR_FILE_BASE = 8'h20;
  // status register bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_PDOWN = 4;
  localparam int ST_SLEEP = 5;
  // command word fields
  localparam int CMD_LIT_LSB = 0;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_DEST_BIT = 11;
  localparam int CMD_OP_LSB = 12;
  // watchdog register fields
  localparam int WDOG_CNT_LSB = 0;
  localparam int WDOG_PRE_LSB = 8;
  // reset and clear values
  localparam logic [DW-1:0] ACC_RST = 8'h00;
  localparam logic [DW-1:0] FILE_RST = 8'h00;
  localparam logic [DW-1:0] WDOG_CLEAR = 8'h00;
  localparam logic TIMEOUT_RST = 1'b1;
  localparam logic PDOWN_RST = 1'b1;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    rotate_left_op = 2'b00,
    rotate_right_op = 2'b01,
    literal_minus_acc_op = 2'b10,
    sleep_op = 2'b11
  } rsx_op_t;
endpackage
`default_nettype wire

// File: rsx_core_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rsx_core_if;
  import rsx_pkg::*;
  rsx_op_t op;
  logic [DW-1:0] literal;
  logic [DW-1:0] acc;
  logic [DW-1:0] fval;
  logic carry_in;
  logic [DW-1:0] result;
  logic carry_out;
  logic nibble_out;
  logic zero_out;
  logic sleep_go;
  logic sw_status_we;
  logic sw_timeout;
  logic sw_power_down;
  logic sw_wdog_we;
  logic [DW-1:0] sw_wdog_count;
  logic [DW-1:0] sw_wdog_prescale;
  logic sleeping;
  logic timeout_flag;
  logic power_down_flag;
  logic [DW-1:0] watchdog_counter;
  logic [DW-1:0] watchdog_prescaler;
  modport core (output op, literal, acc, fval, carry_in, sleep_go, sw_status_we, sw_timeout,
    sw_power_down, sw_wdog_we, sw_wdog_count, sw_wdog_prescale,
    input result, carry_out, nibble_out, zero_out, sleeping, timeout_flag, power_down_flag,
    watchdog_counter, watchdog_prescaler);
  modport alu (input op, literal, acc, fval, carry_in,
    output result, carry_out, nibble_out, zero_out);
  modport sleep_ctl (input sleep_go, sw_status_we, sw_timeout, sw_power_down, sw_wdog_we,
    sw_wdog_count, sw_wdog_prescale,
    output sleeping, timeout_flag, power_down_flag, watchdog_counter, watchdog_prescaler);
endinterface
`default_nettype wire

// File: rsx_alu.sv
`timescale 1ns/10ps
`default_nettype none
module rsx_alu (
  rsx_core_if.alu ex
);
  import rsx_pkg::*;
  logic [DW:0] diff;
  logic [4:0] low_diff;

  // widened differences so the top bit is the borrow
  assign diff = {1'b0, ex.literal} - {1'b0, ex.acc};
  assign low_diff = {1'b0, ex.literal[3:0]} - {1'b0, ex.acc[3:0]};
  assign ex.zero_out = (diff[DW-1:0] == 8'h00);

  // result and carry per operation
  always_comb begin
    ex.result = ex.acc;
    ex.carry_out = ex.carry_in;
    ex.nibble_out = ~low_diff[4];
    unique case (ex.op)
      rotate_left_op: begin
        ex.result = {ex.fval[DW-2:0], ex.carry_in}; // RULE1
        ex.carry_out = ex.fval[DW-1]; // RULE1
      end
      rotate_right_op: begin
        ex.result = {ex.carry_in, ex.fval[DW-1:1]}; // RULE3
        ex.carry_out = ex.fval[0]; // RULE3
      end
      literal_minus_acc_op: begin
        ex.result = diff[DW-1:0]; // RULE8
        ex.carry_out = ~diff[DW]; // RULE9
      end
      sleep_op: begin
        ex.result = ex.acc;
      end
    endcase
  end
endmodule // rsx_alu
`default_nettype wire

// File: rsx_sleep_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module rsx_sleep_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wake_pin,
  rsx_core_if.sleep_ctl ctl
);
  import rsx_pkg::*;
  logic wake_meta;
  logic wake_sync;
  logic sleeping, next_sleeping;
  logic timeout_flag, next_timeout_flag;
  logic power_down_flag, next_power_down_flag;
  logic [DW-1:0] watchdog_counter, next_watchdog_counter;
  logic [DW-1:0] watchdog_prescaler, next_watchdog_prescaler;

  assign ctl.sleeping = sleeping;
  assign ctl.timeout_flag = timeout_flag;
  assign ctl.power_down_flag = power_down_flag;
  assign ctl.watchdog_counter = watchdog_counter;
  assign ctl.watchdog_prescaler = watchdog_prescaler;

  // wake pin is asynchronous; only the second stage is looked at
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
    end
  end

  // sleep entry outranks software writes; both cannot come from one bus write anyway
  always_comb begin
    next_sleeping = sleeping;
    next_timeout_flag = timeout_flag;
    next_power_down_flag = power_down_flag;
    next_watchdog_counter = watchdog_counter;
    next_watchdog_prescaler = watchdog_prescaler;
    if (ctl.sleep_go) begin
      next_power_down_flag = 1'b0; // RULE5
      next_timeout_flag = 1'b1; // RULE5
      next_watchdog_counter = WDOG_CLEAR; // RULE6
      next_watchdog_prescaler = WDOG_CLEAR; // RULE6
      next_sleeping = 1'b1; // RULE7
    end else begin
      if (sleeping && wake_sync) begin
        next_sleeping = 1'b0;
      end
      if (ctl.sw_status_we) begin
        next_timeout_flag = ctl.sw_timeout;
        next_power_down_flag = ctl.sw_power_down;
      end
      if (ctl.sw_wdog_we) begin
        next_watchdog_counter = ctl.sw_wdog_count;
        next_watchdog_prescaler = ctl.sw_wdog_prescale;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleeping <= 1'b0;
      timeout_flag <= TIMEOUT_RST;
      power_down_flag <= PDOWN_RST;
      watchdog_counter <= WDOG_CLEAR;
      watchdog_prescaler <= WDOG_CLEAR;
    end else begin
      sleeping <= next_sleeping;
      timeout_flag <= next_timeout_flag;
      power_down_flag <= next_power_down_flag;
      watchdog_counter <= next_watchdog_counter;
      watchdog_prescaler <= next_watchdog_prescaler;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sleep_entered;
    ctl.sleep_go ##1 ctl.sleeping;
  endsequence

  property p_sleep_flags;
    ctl.sleep_go |=> !power_down_flag && timeout_flag;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong"); // RULE5

  property p_sleep_wdog;
    ctl.sleep_go |=> (watchdog_counter == 8'h00) && (watchdog_prescaler == 8'h00);
  endproperty
  a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared"); // RULE6

  property p_sleep_halt;
    s_sleep_entered ##0 !wake_sync |=> ctl.sleeping;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sleep left early"); // RULE7
endmodule // rsx_sleep_ctl
`default_nettype wire

// File: rsx_exec_top.sv
// Operation
// [RULE1] rotate left: old carry into bit 0, old bit 7 into carry
// [RULE2] rotate left result goes to accumulator when dest 0, file register when 1
// [RULE3] rotate right: old carry into bit 7, old bit 0 into carry
// [RULE4] rotate right result goes to accumulator when dest 0, file register when 1
// [RULE5] sleep clears the power-down flag and sets the timeout flag
// [RULE6] sleep clears the watchdog counter and its prescaler
// [RULE7] after sleep the core halts execution and stops the oscillator
// [RULE8] literal minus accumulator, two's complement, result into accumulator
// [RULE9] carry and nibble flag are one unless accumulator part exceeds literal part
// [RULE10] subtract sets zero from result; rotates touch only carry
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module rsx_exec_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wake_pin,
  input wire logic [rsx_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rsx_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rsx_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rsx_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic osc_stop
);
  import rsx_pkg::*;

  rsx_core_if cif();

  // bus slave holding registers
  logic aw_full, next_aw_full;
  logic [AXI_AW-1:0] aw_addr, next_aw_addr;
  logic w_full, next_w_full;
  logic [AXI_DW-1:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [AXI_DW-1:0] next_rdata, rd_word;
  logic rd_mapped;
  // core state
  logic [DW-1:0] acc, next_acc;
  logic carry, next_carry;
  logic nibble_borrow_inverse_bit, next_nibble_borrow_inverse_bit;
  logic zero, next_zero;
  logic [CMD_W-1:0] cmd_last, next_cmd_last;
  logic [DW-1:0] file_mem [FILE_DEPTH];
  // write decode
  logic do_write, wr_acc, wr_status, wr_cmd, wr_wdog, wr_file, wr_mapped, issue;
  logic [FILE_IDX_W-1:0] cmd_idx;
  logic cmd_dest;
  rsx_op_t cmd_op;

  assign osc_stop = cif.sleeping; // RULE7

  rsx_alu u_alu (
    .ex(cif)
  );

  rsx_sleep_ctl u_sleep (
    .aclk(aclk),
    .aresetn(aresetn),
    .wake_pin(wake_pin),
    .ctl(cif)
  );

  // a write is carried out once both address and data are held and no answer is pending
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_acc = do_write && (aw_addr[7:2] == ADDR_ACC[7:2]);
  assign wr_status = do_write && (aw_addr[7:2] == ADDR_STATUS[7:2]);
  assign wr_cmd = do_write && (aw_addr[7:2] == ADDR_CMD[7:2]);
  assign wr_wdog = do_write && (aw_addr[7:2] == ADDR_WDOG[7:2]);
  assign wr_file = do_write && (aw_addr[7:5] == ADDR_FILE_BASE[7:5]);
  assign wr_mapped = wr_acc || wr_status || wr_cmd || wr_wdog || wr_file;

  // command fields; both low byte lanes must be written to issue
  assign cmd_op = rsx_op_t'(w_data[CMD_OP_LSB +: 2]);
  assign cmd_dest = w_data[CMD_DEST_BIT];
  assign cmd_idx = w_data[CMD_IDX_LSB +: FILE_IDX_W];
  assign issue = wr_cmd && (&w_strb[1:0]) && !cif.sleeping; // RULE7

  // operands into the shared datapath
  assign cif.op = cmd_op;
  assign cif.literal = w_data[CMD_LIT_LSB +: DW];
  assign cif.acc = acc;
  assign cif.fval = file_mem[cmd_idx];
  assign cif.carry_in = carry;
  assign cif.sleep_go = issue && (cmd_op == sleep_op);
  assign cif.sw_status_we = wr_status && w_strb[0];
  assign cif.sw_timeout = w_data[ST_TIMEOUT];
  assign cif.sw_power_down = w_data[ST_PDOWN];
  assign cif.sw_wdog_we = wr_wdog && (&w_strb[1:0]);
  assign cif.sw_wdog_count = w_data[WDOG_CNT_LSB +: DW];
  assign cif.sw_wdog_prescale = w_data[WDOG_PRE_LSB +: DW];

  // write channels and response
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_full;
    next_wready = !next_w_full;
  end

  // read decode; reserved bits read as zero
  always_comb begin
    rd_word = '0;
    rd_mapped = 1'b1;
    if (s_axi_araddr[7:2] == ADDR_ACC[7:2]) begin
      rd_word[DW-1:0] = acc;
    end else if (s_axi_araddr[7:2] == ADDR_STATUS[7:2]) begin
      rd_word[ST_CARRY] = carry;
      rd_word[ST_NIBBLE] = nibble_borrow_inverse_bit;
      rd_word[ST_ZERO] = zero;
      rd_word[ST_TIMEOUT] = cif.timeout_flag;
      rd_word[ST_PDOWN] = cif.power_down_flag;
      rd_word[ST_SLEEP] = cif.sleeping;
    end else if (s_axi_araddr[7:2] == ADDR_CMD[7:2]) begin
      rd_word[CMD_W-1:0] = cmd_last;
    end else if (s_axi_araddr[7:2] == ADDR_WDOG[7:2]) begin
      rd_word[WDOG_CNT_LSB +: DW] = cif.watchdog_counter;
      rd_word[WDOG_PRE_LSB +: DW] = cif.watchdog_prescaler;
    end else if (s_axi_araddr[7:5] == ADDR_FILE_BASE[7:5]) begin
      rd_word[DW-1:0] = file_mem[s_axi_araddr[4:2]];
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // read channel: data is captured when the address is taken
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // accumulator and flags; an issued command outranks a direct register write
  always_comb begin
    next_acc = acc;
    next_carry = carry;
    next_nibble_borrow_inverse_bit = nibble_borrow_inverse_bit;
    next_zero = zero;
    next_cmd_last = cmd_last;
    if (issue) begin
      next_cmd_last = w_data[CMD_W-1:0];
      unique case (cmd_op)
        rotate_left_op, rotate_right_op: begin
          next_carry = cif.carry_out; // RULE1 RULE3 RULE10
          if (!cmd_dest) begin
            next_acc = cif.result; // RULE2 RULE4
          end
        end
        literal_minus_acc_op: begin
          next_acc = cif.result; // RULE8
          next_carry = cif.carry_out; // RULE9
          next_nibble_borrow_inverse_bit = cif.nibble_out; // RULE9
          next_zero = cif.zero_out; // RULE10
        end
        sleep_op: begin
          next_acc = acc;
        end
      endcase
    end else if (wr_acc && w_strb[0]) begin
      next_acc = w_data[DW-1:0];
    end else if (wr_status && w_strb[0]) begin
      next_carry = w_data[ST_CARRY];
      next_nibble_borrow_inverse_bit = w_data[ST_NIBBLE];
      next_zero = w_data[ST_ZERO];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= ACC_RST;
      carry <= 1'b0;
      nibble_borrow_inverse_bit <= 1'b0;
      zero <= 1'b0;
      cmd_last <= '0;
    end else begin
      acc <= next_acc;
      carry <= next_carry;
      nibble_borrow_inverse_bit <= next_nibble_borrow_inverse_bit;
      zero <= next_zero;
      cmd_last <= next_cmd_last;
    end
  end

  // file registers, one entry per generate step
  for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
    logic [DW-1:0] next_entry;
    logic sw_hit, rot_hit;
    assign sw_hit = wr_file && w_strb[0] && (aw_addr[4:2] == FILE_IDX_W'(i));
    assign rot_hit = issue && cmd_dest && (cmd_idx == FILE_IDX_W'(i)) &&
      ((cmd_op == rotate_left_op) || (cmd_op == rotate_right_op));
    always_comb begin
      next_entry = file_mem[i];
      if (rot_hit) begin
        next_entry = cif.result; // RULE2 RULE4
      end else if (sw_hit) begin
        next_entry = w_data[DW-1:0];
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        file_mem[i] <= FILE_RST;
      end else begin
        file_mem[i] <= next_entry;
      end
    end
  end

  // copies of the issue cycle, read only by the checks below
  logic issue_q, dest_q, carry_q, nib_q, zero_q;
  rsx_op_t op_q;
  logic [FILE_IDX_W-1:0] idx_q;
  logic [DW-1:0] fval_q, acc_q, lit_q;
  always_ff @(posedge aclk) begin
    issue_q <= aresetn && issue;
    op_q <= cmd_op;
    dest_q <= cmd_dest;
    idx_q <= cmd_idx;
    fval_q <= cif.fval;
    acc_q <= acc;
    lit_q <= cif.literal;
    carry_q <= carry;
    nib_q <= nibble_borrow_inverse_bit;
    zero_q <= zero;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rotl_value;
    issue_q && op_q == rotate_left_op && !dest_q |-> acc == {fval_q[6:0], carry_q} && carry == fval_q[7];
  endproperty
  a_rotl_value: assert property (p_rotl_value) else $error("rotate left wrong"); // RULE1

  property p_rotl_dest;
    issue_q && op_q == rotate_left_op && dest_q |-> file_mem[idx_q] == {fval_q[6:0], carry_q} && acc == acc_q;
  endproperty
  a_rotl_dest: assert property (p_rotl_dest) else $error("rotate left dest wrong"); // RULE2

  property p_rotr_value;
    issue_q && op_q == rotate_right_op && !dest_q |-> acc == {carry_q, fval_q[7:1]} && carry == fval_q[0];
  endproperty
  a_rotr_value: assert property (p_rotr_value) else $error("rotate right wrong"); // RULE3

  property p_rotr_dest;
    issue_q && op_q == rotate_right_op && dest_q |-> file_mem[idx_q] == {carry_q, fval_q[7:1]} && acc == acc_q;
  endproperty
  a_rotr_dest: assert property (p_rotr_dest) else $error("rotate right dest wrong"); // RULE4

  property p_refuse_asleep;
    wr_cmd && cif.sleeping |=> acc == acc_q && carry == carry_q && zero == zero_q;
  endproperty
  a_refuse_asleep: assert property (p_refuse_asleep) else $error("command ran asleep"); // RULE7

  property p_sub_value;
    issue_q && op_q == literal_minus_acc_op |-> acc == 8'(lit_q - acc_q);
  endproperty
  a_sub_value: assert property (p_sub_value) else $error("subtract wrong"); // RULE8

  property p_sub_flags;
    issue_q && op_q == literal_minus_acc_op |->
      carry == (acc_q <= lit_q) && nibble_borrow_inverse_bit == (acc_q[3:0] <= lit_q[3:0]);
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong"); // RULE9

  property p_flags_other;
    issue_q |-> (op_q == literal_minus_acc_op) ? zero == (acc == 8'h00) :
      (zero == zero_q && nibble_borrow_inverse_bit == nib_q);
  endproperty
  a_flags_other: assert property (p_flags_other) else $error("zero or keep wrong"); // RULE10
endmodule // rsx_exec_top
`default_nettype wire

// File: tb_rotate_subtract_sleep_exec.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_rotate_subtract_sleep_exec;
  import rsx_pkg::*;
  logic aclk, aresetn, wake_pin;
  logic [AXI_AW-1:0] awaddr, araddr, faddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [AXI_DW-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, osc_stop;
  logic [1:0] bresp, rresp, op;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [33:0] r_exp;
  logic [1:0] b_exp;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  integer seed = 32'hb66df299;
  // bench copy of the block state
  logic [DW-1:0] acc_m, lit, fv, r;
  logic [DW-1:0] file_m[FILE_DEPTH];
  logic [FILE_IDX_W-1:0] idx;
  logic [4:0] sv;
  logic dest, c_m, n_m, z_m, tmo_m, pwr_m;

  rsx_exec_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .wake_pin(wake_pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_stop(osc_stop)
  );

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far above the under a thousand cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end

  // monitor: each answer is matched against the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      r_exp = rq.pop_front();
      `CHK({rresp, rdata}, r_exp)
    end
    if (bvalid && bready) begin
      b_exp = bq.pop_front();
      `CHK(bresp, b_exp)
    end
  end

  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // read: the expected word is noted before the request goes out
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    rq.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic [31:0] st(input logic slp);
    return {26'h0, slp, pwr_m, tmo_m, z_m, n_m, c_m};
  endfunction

  initial begin
    {aresetn, wake_pin, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {acc_m, c_m, n_m, z_m} = '0;
    {tmo_m, pwr_m} = 2'b11;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset values and an unmapped hole
    axr(ADDR_ACC, 32'h0, RESP_OKAY);
    axr(ADDR_STATUS, st(1'b0), RESP_OKAY);
    axr(ADDR_WDOG, 32'h0, RESP_OKAY);
    axr(8'h10, 32'h0, RESP_SLVERR);
    axw(8'h14, 32'h0, RESP_SLVERR);
    $display("test reset_and_map done");
    // rotates and subtract on random operands, every op and both destinations
    for (int i = 0; i < 30; i++) begin
      op = 2'(i % 3);
      lit = 8'($random(seed));
      idx = 3'($random(seed));
      dest = 1'($random(seed));
      fv = 8'($random(seed));
      acc_m = (i % 6 == 2) ? lit : 8'($random(seed)); // equal operands hit zero result
      sv = 5'($random(seed));
      {pwr_m, tmo_m, z_m, n_m, c_m} = sv;
      file_m[idx] = fv;
      faddr = ADDR_FILE_BASE + {3'b000, idx, 2'b00};
      axw(ADDR_ACC, {24'h0, acc_m}, RESP_OKAY);
      axw(faddr, {24'h0, fv}, RESP_OKAY);
      axw(ADDR_STATUS, {27'h0, sv}, RESP_OKAY);
      case (op)
        2'd0: begin
          r = {fv[6:0], c_m};
          c_m = fv[7];
        end
        2'd1: begin
          r = {c_m, fv[7:1]};
          c_m = fv[0];
        end
        default: begin
          r = lit - acc_m;
          c_m = acc_m <= lit;
          n_m = acc_m[3:0] <= lit[3:0];
          z_m = r == 8'h00;
        end
      endcase
      if (op == 2'd2 || !dest) acc_m = r;
      else file_m[idx] = r;
      axw(ADDR_CMD, {18'h0, op, dest, idx, lit}, RESP_OKAY);
      axr(ADDR_ACC, {24'h0, acc_m}, RESP_OKAY);
      axr(faddr, {24'h0, file_m[idx]}, RESP_OKAY);
      axr(ADDR_STATUS, st(1'b0), RESP_OKAY);
    end
    $display("test rotate_subtract done");
    // sleep from a state where both status bits must flip
    {pwr_m, tmo_m} = 2'b10;
    axw(ADDR_STATUS, st(1'b0), RESP_OKAY);
    axw(ADDR_WDOG, 32'h5a3c, RESP_OKAY);
    // the watchdog must hold a non-zero value, or the clear below proves nothing
    axr(ADDR_WDOG, 32'h5a3c, RESP_OKAY);
    axw(ADDR_CMD, {18'h0, 2'b11, 12'h000}, RESP_OKAY);
    {pwr_m, tmo_m} = 2'b01;
    `CHK(osc_stop, 1'b1)
    axr(ADDR_STATUS, st(1'b1), RESP_OKAY);
    axr(ADDR_WDOG, 32'h0, RESP_OKAY);
    // a command while asleep must not execute
    axw(ADDR_CMD, {18'h0, 2'b10, 12'h0ff}, RESP_OKAY);
    axr(ADDR_ACC, {24'h0, acc_m}, RESP_OKAY);
    // the refused command must not replace the last issued one
    axr(ADDR_CMD, 32'h3000, RESP_OKAY);
    $display("test sleep done");
    // wake goes through a two-flop sync, so allow a fourth edge
    wake_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(osc_stop, 1'b0)
    wake_pin <= 1'b0;
    @(posedge aclk);
    axr(ADDR_STATUS, st(1'b0), RESP_OKAY);
    $display("test wake done");
    wrap_up();
  end
endmodule // tb_rotate_subtract_sleep_exec
`default_nettype wire
